// ==== hdl/lctc_top.v ====
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "lctc_consts.vh"
module lctc_top
(
  core_clk,
  reset_n,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  rxTermPin,
  refT1Clk,
  refE1Clk,
  ref8kClk,
  t1ClkOut,
  e1ClkOut,
  clk8kOut,
  refFreqKhz,
  termOhms,
  chT1Clk,
  chE1Clk,
  chIsE1,
  chRxTermOn,
  chResOhms
);
  input wire core_clk;
  input wire reset_n;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output wire pslverr;
  input wire rxTermPin;
  input wire refT1Clk;
  input wire refE1Clk;
  input wire ref8kClk;
  output wire t1ClkOut;
  output wire e1ClkOut;
  output wire clk8kOut;
  output reg [14:0] refFreqKhz;
  output reg [7:0] termOhms;
  output wire [13:0] chT1Clk;
  output wire [13:0] chE1Clk;
  output reg [13:0] chIsE1;
  output reg [13:0] chRxTermOn;
  output reg [111:0] chResOhms;

  reg [8:0] global_q;
  reg [`LCTC_C_W*`LCTC_NCH-1:0] chan_q;
  wire [3:0] inputClockSelect;
  wire singleRateClockDisable;
  wire globalT1Mode;
  wire [1:0] terminationSelect;
  wire rxTerminationPinControl;
  wire pinSync;
  wire t1Enable;
  wire e1Enable;
  wire k8Enable;
  wire t1On;
  wire e1On;
  wire k8On;
  wire t1Stat;
  wire e1Stat;
  wire k8Stat;
  wire apbWrite;
  wire isGlobal;
  wire isStat;
  wire isChan;
  wire [11:0] chOffset;
  wire [3:0] chIdx;
  reg [31:0] rdData;
  integer i;

  assign inputClockSelect = global_q[`LCTC_G_CLKSEL_HI:`LCTC_G_CLKSEL_LO];
  assign singleRateClockDisable = global_q[`LCTC_G_SRDIS];
  assign globalT1Mode = global_q[`LCTC_G_T1MODE];
  assign terminationSelect = global_q[`LCTC_G_TERSEL_HI:`LCTC_G_TERSEL_LO];
  assign rxTerminationPinControl = global_q[`LCTC_G_PINCTL];

  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  assign pready = 1'b1;
  assign apbWrite = psel & penable & pwrite;
  assign isGlobal = (paddr == `LCTC_ADDR_GLOBAL);
  assign isStat = (paddr == `LCTC_ADDR_CLKSTAT);
  assign chOffset = paddr - `LCTC_ADDR_CH0;
  assign chIdx = chOffset[5:2];
  assign isChan = (paddr >= `LCTC_ADDR_CH0) && (chOffset[1:0] == 2'b00)
    && (chOffset[11:2] < `LCTC_NCH);
  assign pslverr = psel & penable & ~(isGlobal | isStat | isChan);

  // disable bit and others reset to zero
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      global_q <= `LCTC_G_RESET;
    else if (apbWrite && isGlobal)
      global_q <= pwdata[8:0];
  end

  // channel registers reset with termination off, no resistor
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      chan_q <= {`LCTC_NCH{`LCTC_C_RESET}};
    else if (apbWrite && isChan)
      chan_q[chIdx*`LCTC_C_W +: `LCTC_C_W] <= pwdata[`LCTC_C_W-1:0];
  end

  always @*
  begin
    rdData = 32'h00000000;
    if (isGlobal)
      rdData = {23'h0, global_q};
    else if (isStat)
      rdData = {28'h0, pinSync, k8Stat, e1Stat, t1Stat};
    else if (isChan)
      rdData = {26'h0, chan_q[chIdx*`LCTC_C_W +: `LCTC_C_W]};
  end

  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= rdData;
  end

  // ----------------------------------------
  // Reference frequency and impedance decode
  // ----------------------------------------
  // input reference select decode
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      refFreqKhz <= `LCTC_F_2048;
    else
    begin
      case (inputClockSelect)
        4'h0: refFreqKhz <= `LCTC_F_2048;
        4'h1: refFreqKhz <= `LCTC_F_1544;
        4'h2: refFreqKhz <= `LCTC_F_8;
        4'h3: refFreqKhz <= `LCTC_F_16;
        4'h4: refFreqKhz <= `LCTC_F_56;
        4'h5: refFreqKhz <= `LCTC_F_64;
        4'h6: refFreqKhz <= `LCTC_F_128;
        4'h7: refFreqKhz <= `LCTC_F_256;
        4'h8: refFreqKhz <= `LCTC_F_4096;
        4'h9: refFreqKhz <= `LCTC_F_3088;
        4'ha: refFreqKhz <= `LCTC_F_8192;
        4'hb: refFreqKhz <= `LCTC_F_6176;
        4'hc: refFreqKhz <= `LCTC_F_16384;
        4'hd: refFreqKhz <= `LCTC_F_12352;
        4'he: refFreqKhz <= `LCTC_F_2048;
        default: refFreqKhz <= `LCTC_F_1544;
      endcase
    end
  end

  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      termOhms <= `LCTC_Z_100;
    else
    begin
      case (terminationSelect)
        2'h0: termOhms <= `LCTC_Z_100;
        2'h1: termOhms <= `LCTC_Z_110;
        2'h2: termOhms <= `LCTC_Z_75;
        default: termOhms <= `LCTC_Z_120;
      endcase
    end
  end

  // ----------------------------------------
  // Hardware termination pin
  // ----------------------------------------
  // two-stage synchroniser
  lctc_sync2 pinSyncInst
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .asyncIn(rxTermPin),
    .syncOut(pinSync)
  );

  // ----------------------------------------
  // Per-channel decode
  // ----------------------------------------
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      chIsE1 <= 14'h0000;
      chRxTermOn <= 14'h0000;
      chResOhms <= 112'h0;
    end
    else
    begin
      for (i = 0; i < `LCTC_NCH; i = i + 1)
      begin
        chIsE1[i] <= (chan_q[i*`LCTC_C_W+`LCTC_C_EQ_LO +: 3]
          >= `LCTC_EQ_E1_MIN);
        chRxTermOn[i] <= rxTerminationPinControl ? pinSync
          : chan_q[i*`LCTC_C_W+`LCTC_C_RXTEN];
        case (chan_q[i*`LCTC_C_W+`LCTC_C_RES_LO +: 2])
          2'h0: chResOhms[i*8 +: 8] <= `LCTC_Z_NONE;
          2'h1: chResOhms[i*8 +: 8] <= `LCTC_Z_240;
          2'h2: chResOhms[i*8 +: 8] <= `LCTC_Z_210;
          default: chResOhms[i*8 +: 8] <= `LCTC_Z_150;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Single-rate clock gating
  // ----------------------------------------
  // disable bit keeps all running
  // T1 mode stops E1 and 8 kHz
  // E1 mode stops T1, keeps 8 kHz
  assign t1Enable = singleRateClockDisable | globalT1Mode;
  assign e1Enable = singleRateClockDisable | ~globalT1Mode;
  assign k8Enable = singleRateClockDisable | ~globalT1Mode;

  lctc_gate t1Gate
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .refClk(refT1Clk),
    .enable(t1Enable),
    .gatedClk(t1ClkOut),
    .gateOn(t1On)
  );
  lctc_gate e1Gate
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .refClk(refE1Clk),
    .enable(e1Enable),
    .gatedClk(e1ClkOut),
    .gateOn(e1On)
  );
  lctc_gate k8Gate
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .refClk(ref8kClk),
    .enable(k8Enable),
    .gatedClk(clk8kOut),
    .gateOn(k8On)
  );

  // Gate state retimed from reference domain for readback
  lctc_sync2 t1StatSync
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .asyncIn(t1On),
    .syncOut(t1Stat)
  );
  lctc_sync2 e1StatSync
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .asyncIn(e1On),
    .syncOut(e1Stat)
  );
  lctc_sync2 k8StatSync
  (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .asyncIn(k8On),
    .syncOut(k8Stat)
  );

  assign chT1Clk = {`LCTC_NCH{t1ClkOut}};
  assign chE1Clk = {`LCTC_NCH{e1ClkOut}};
endmodule

// ==== hdl/lctc_consts.vh ====
`ifndef LCTC_CONSTS_VH
`define LCTC_CONSTS_VH
// ----------------------------------------
// Channel count and register map
// ----------------------------------------
`define LCTC_NCH 14
`define LCTC_ADDR_GLOBAL 12'h000
`define LCTC_ADDR_CLKSTAT 12'h004
`define LCTC_ADDR_CH0 12'h040
`define LCTC_CH_STRIDE 12'h004
`define LCTC_ADDR_W 12
// ----------------------------------------
// Global register fields
// ----------------------------------------
`define LCTC_G_CLKSEL_LO 0
`define LCTC_G_CLKSEL_HI 3
`define LCTC_G_SRDIS 4
`define LCTC_G_T1MODE 5
`define LCTC_G_TERSEL_LO 6
`define LCTC_G_TERSEL_HI 7
`define LCTC_G_PINCTL 8
`define LCTC_G_RESET 9'h000
// ----------------------------------------
// Channel register fields
// ----------------------------------------
`define LCTC_C_EQ_LO 0
`define LCTC_C_EQ_HI 2
`define LCTC_C_RXTEN 3
`define LCTC_C_RES_LO 4
`define LCTC_C_RES_HI 5
`define LCTC_C_RESET 6'h00
`define LCTC_C_W 6
`define LCTC_EQ_E1_MIN 3'h4
// ----------------------------------------
// Reference frequency in kHz, 15 bits
// ----------------------------------------
`define LCTC_F_2048 15'h0800
`define LCTC_F_1544 15'h0608
`define LCTC_F_8 15'h0008
`define LCTC_F_16 15'h0010
`define LCTC_F_56 15'h0038
`define LCTC_F_64 15'h0040
`define LCTC_F_128 15'h0080
`define LCTC_F_256 15'h0100
`define LCTC_F_4096 15'h1000
`define LCTC_F_3088 15'h0c10
`define LCTC_F_8192 15'h2000
`define LCTC_F_6176 15'h1820
`define LCTC_F_16384 15'h4000
`define LCTC_F_12352 15'h3040
// ----------------------------------------
// Impedance codes in ohms, 8 bits
// ----------------------------------------
`define LCTC_Z_100 8'h64
`define LCTC_Z_110 8'h6e
`define LCTC_Z_75 8'h4b
`define LCTC_Z_120 8'h78
`define LCTC_Z_NONE 8'h00
`define LCTC_Z_240 8'hf0
`define LCTC_Z_210 8'hd2
`define LCTC_Z_150 8'h96
`endif

// ==== hdl/lctc_sync2.v ====
`timescale 1ns/10ps
module lctc_sync2
(
  core_clk,
  reset_n,
  asyncIn,
  syncOut
);
  input wire core_clk;
  input wire reset_n;
  input wire asyncIn;
  output wire syncOut;
  reg stage1_q;
  reg stage2_q;
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end
    else
    begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end
  assign syncOut = stage2_q;
endmodule

// ==== hdl/lctc_gate.v ====
`timescale 1ns/10ps
// ----------------------------------------
// Glitch-free clock gate, enable flop on falling edge
// ----------------------------------------
module lctc_gate
(
  core_clk,
  reset_n,
  refClk,
  enable,
  gatedClk,
  gateOn
);
  input wire core_clk;
  input wire reset_n;
  input wire refClk;
  input wire enable;
  output wire gatedClk;
  output wire gateOn;
  reg enSync_q;
  reg en_q;
  // Enable retimed, then updated only while reference is low
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      enSync_q <= 1'b1;
    else
      enSync_q <= enable;
  end
  always @(negedge refClk or negedge reset_n)
  begin
    if (!reset_n)
      en_q <= 1'b1;
    else
      en_q <= enSync_q;
  end
  assign gatedClk = refClk & en_q;
  assign gateOn = en_q;
endmodule

// ==== tb/lctc_top_sva.sv ====
`timescale 1ns/10ps
`include "lctc_consts.vh"
module lctc_top_sva
(
  input wire core_clk,
  input wire reset_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire rxTermPin,
  input wire refT1Clk,
  input wire refE1Clk,
  input wire ref8kClk,
  input wire t1ClkOut,
  input wire e1ClkOut,
  input wire clk8kOut,
  input wire [7:0] termOhms,
  input wire [13:0] chT1Clk,
  input wire [13:0] chE1Clk,
  input wire [13:0] chRxTermOn
);
  // ----------------------------------------
  // Mirror of global settings
  // ----------------------------------------
  localparam [31:0] ZT = {`LCTC_Z_120, `LCTC_Z_75, `LCTC_Z_110, `LCTC_Z_100};
  wire wr = psel && penable && pwrite && pready;
  wire gw = wr && paddr == 12'h000;
  wire cw = wr && paddr >= 12'h040 && paddr < 12'h078;
  wire [1:0] ts = pwdata[7:6];
  reg [3:0] age_q;
  reg [2:0] pinAge_q;
  reg sr_q, t1_q, pc_q, pin_q;
  always @(posedge core_clk or negedge reset_n)
    if (!reset_n)
      {age_q, pinAge_q, sr_q, t1_q, pc_q, pin_q} <= 11'h000;
    else
    begin
      pin_q <= rxTermPin;
      if (gw)
        {age_q, pc_q, t1_q, sr_q} <= {4'h0, pwdata[8], pwdata[5:4]};
      else if (age_q != 4'hf)
        age_q <= age_q + 4'h1;
      if (rxTermPin != pin_q)
        pinAge_q <= 3'h0;
      else if (pinAge_q != 3'h7)
        pinAge_q <= pinAge_q + 3'h1;
    end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_e1Off;
    age_q >= 10 && !sr_q && t1_q |-> !e1ClkOut && !clk8kOut;
  endproperty
  a_e1Off: assert property (p_e1Off) else $error("E1 clock on");
  property p_t1Off;
    age_q >= 10 && !sr_q && !t1_q |-> !t1ClkOut && clk8kOut == ref8kClk;
  endproperty
  a_t1Off: assert property (p_t1Off) else $error("T1 clock on");
  property p_allOn;
    age_q >= 10 && sr_q |-> t1ClkOut == refT1Clk && e1ClkOut == refE1Clk;
  endproperty
  a_allOn: assert property (p_allOn) else $error("clock gated");
  property p_fanOut;
    chT1Clk == {14{t1ClkOut}} && chE1Clk == {14{e1ClkOut}};
  endproperty
  a_fanOut: assert property (p_fanOut) else $error("fan out");
  property p_term;
    gw |=> ##1 termOhms == ZT[$past(ts, 2) * 8 +: 8];
  endproperty
  a_term: assert property (p_term) else $error("impedance");
  property p_pinSync;
    pc_q && age_q >= 4 && pinAge_q >= 3 && $changed(rxTermPin) |=>
      $stable(chRxTermOn) ##2 chRxTermOn == {14{$past(rxTermPin, 3)}};
  endproperty
  a_pinSync: assert property (p_pinSync) else $error("pin path");
  property p_pinOff;
    !pc_q && age_q >= 3 && !$past(cw) |=> $stable(chRxTermOn);
  endproperty
  a_pinOff: assert property (p_pinOff) else $error("pin leak");
  property p_noRunt;
    $changed(t1ClkOut) |-> $changed(refT1Clk) && t1ClkOut == refT1Clk;
  endproperty
  a_noRunt: assert property (p_noRunt) else $error("runt pulse");
  c_srWrite: cover property (gw && pwdata[4]);
  c_pinMove: cover property (pc_q && $changed(rxTermPin));
  c_chWrite: cover property (cw);
  c_t1Only: cover property (age_q >= 10 && !sr_q && t1_q);
endmodule
bind lctc_top lctc_top_sva u_sva
(
  .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .rxTermPin(rxTermPin), .refT1Clk(refT1Clk), .refE1Clk(refE1Clk),
  .ref8kClk(ref8kClk), .t1ClkOut(t1ClkOut), .e1ClkOut(e1ClkOut),
  .clk8kOut(clk8kOut), .termOhms(termOhms), .chT1Clk(chT1Clk),
  .chE1Clk(chE1Clk), .chRxTermOn(chRxTermOn)
);

// ==== tb/lctc_top_tb.sv ====
`timescale 1ns/10ps
`include "lctc_consts.vh"
module lctc_top_tb;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  localparam [239:0] FQT = {`LCTC_F_1544, `LCTC_F_2048, `LCTC_F_12352,
    `LCTC_F_16384, `LCTC_F_6176, `LCTC_F_8192, `LCTC_F_3088, `LCTC_F_4096,
    `LCTC_F_256, `LCTC_F_128, `LCTC_F_64, `LCTC_F_56, `LCTC_F_16,
    `LCTC_F_8, `LCTC_F_1544, `LCTC_F_2048};
  localparam [63:0] ZT = {`LCTC_Z_150, `LCTC_Z_210, `LCTC_Z_240,
    `LCTC_Z_NONE, `LCTC_Z_120, `LCTC_Z_75, `LCTC_Z_110, `LCTC_Z_100};
  reg core_clk = 1'h0;
  reg reset_n = 1'h0;
  reg psel = 1'h0;
  reg penable = 1'h0;
  reg pwrite = 1'h0;
  reg rxTermPin = 1'h0;
  reg [2:0] refClk = 3'h0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [31:0] rd;
  reg err;
  reg [5:0] chv [0:13];
  reg [13:0] expTen;
  wire [31:0] prdata;
  wire pready, pslverr, t1ClkOut, e1ClkOut, clk8kOut;
  wire [14:0] refFreqKhz;
  wire [7:0] termOhms;
  wire [13:0] chT1Clk, chE1Clk, chIsE1, chRxTermOn;
  wire [111:0] chResOhms;
  integer num_errors = 0;
  integer checks = 0;
  integer i;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk)
    refClk <= refClk + 3'h1;
  lctc_top u_dut
  (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxTermPin(rxTermPin), .refT1Clk(refClk[0]), .refE1Clk(refClk[1]),
    .ref8kClk(refClk[2]), .t1ClkOut(t1ClkOut), .e1ClkOut(e1ClkOut),
    .clk8kOut(clk8kOut), .refFreqKhz(refFreqKhz), .termOhms(termOhms),
    .chT1Clk(chT1Clk), .chE1Clk(chE1Clk), .chIsE1(chIsE1),
    .chRxTermOn(chRxTermOn), .chResOhms(chResOhms)
  );
  task chk(input string nm, input [111:0] got, input [111:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        num_errors = num_errors + 1;
        $display("[ERR] %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  function [2:0] exp_gates(input sr, input t1);
    exp_gates = {sr | ~t1, sr | ~t1, sr | t1};
  endfunction
  task wt(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge core_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      @(posedge core_clk);
      while (pready !== 1'h1)
        @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  task rst_chk;
    begin
      reset_n <= 1'h0;
      wt(8);
      chk("freq", refFreqKhz, FQT[14:0]);
      chk("term", termOhms, ZT[7:0]);
      chk("rxTerm", chRxTermOn, 14'h0000);
      chk("res", chResOhms, 112'h0);
      reset_n <= 1'h1;
      apb(1'h0, 12'h000, 32'h0);
      chk("srDis", rd[4], 1'h0);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial
  begin
    wt(5000);
    num_errors = num_errors + 1;
    give_verdict;
  end
  initial
  begin
    rd = $urandom(32'h5fb799f8);
    rst_chk;
    for (i = 0; i < 16; i = i + 1)
    begin
      rd = $urandom;
      apb(1'h1, 12'h000, {rd[31:9], 1'h0, i[2:0], i[3], i[3:0]});
      wt(16);
      chk("freq", refFreqKhz, FQT[i * 15 +: 15]);
      chk("term", termOhms, ZT[i[2:1] * 8 +: 8]);
      apb(1'h0, 12'h004, 32'h0);
      chk("gates", rd[2:0], exp_gates(i[3], i[0]));
    end
    for (i = 0; i < 14; i = i + 1)
    begin
      rd = $urandom;
      if (i < 2)
        rd[2:0] = 3'h3 + i[2:0];
      chv[i] = rd[5:0];
      expTen[i] = rd[3];
      apb(1'h1, 12'h040 + {i[9:0], 2'h0}, rd);
    end
    for (i = 0; i < 14; i = i + 1)
    begin
      apb(1'h0, 12'h040 + {i[9:0], 2'h0}, 32'h0);
      chk("chReg", rd[5:0], chv[i]);
      chk("isE1", chIsE1[i], chv[i][2:0] >= 3'h4);
      chk("rxTerm", chRxTermOn[i], chv[i][3]);
      chk("res", chResOhms[i * 8 +: 8], ZT[(4 + chv[i][5:4]) * 8 +: 8]);
    end
    rxTermPin <= 1'h1;
    wt(6);
    chk("pinOff", chRxTermOn, expTen);
    apb(1'h1, 12'h000, 32'h100);
    for (i = 0; i < 4; i = i + 1)
    begin
      rxTermPin <= i[0];
      wt(6);
      chk("pinOn", chRxTermOn, {14{i[0]}});
    end
    apb(1'h1, 12'h000, 32'h0);
    wt(4);
    chk("pinOff", chRxTermOn, expTen);
    apb(1'h1, 12'h078, 32'h3f);
    chk("slvErr", err, 1'h1);
    apb(1'h0, 12'h100, 32'h0);
    chk("slvErr", err, 1'h1);
    chk("rdata", rd, 32'h0);
    rst_chk;
    give_verdict;
  end
endmodule
